// >>> src/rwcm_top.sv
/*
 * Reset sequencer with watchdog and clock monitor, registers on Avalon-MM.
 * Assumes rst_b is the power-on reset, the reset pin is open drain with a
 * pull-up outside, and mon_clk is the CPU clock seen as a plain pin.
 */
`timescale 1ns/10ps
module rwcm_top
   import rwcm_pkg::*;
#(
   parameter int unsigned WD_BASE_CYC    = WD_BASE_E,
   parameter int unsigned CM_TIMEOUT_CYC = CM_RC_NS / SYS_CLK_NS
) (
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic        clk_en,
   input  wire logic        rst_pin_i,
   output logic             rst_pin_o,
   output logic             rst_pin_oe,
   input  wire logic        special_mode,
   input  wire logic        mon_clk,
   input  wire logic        stop_mode,
   output logic             cpu_reset,
   output logic [15:0]      reset_vector,
   output logic [1:0]       reset_cause,
   input  wire logic [17:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest
);

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic [2:0]  meta_reg;
   logic [2:0]  sync_reg;
   logic        mc_prev_reg;
   logic        pin_s;
   logic        mode_s;
   logic [1:0]  ediv_reg;
   logic        e_tick;
   rwcm_state_e state_reg;
   logic [11:0] seq_cnt_reg;
   rwcm_cause_e pend_reg;
   logic        in_rst;
   logic        special_reg;
   logic        wd_dis_eff_reg;
   logic        cfg_wddis_reg;
   logic        inhibit_reg;
   rwcm_opt_s   opt_reg;
   logic        rate_done_reg;
   logic [6:0]  win_cnt_reg;
   logic [21:0] wd_cnt_reg;
   logic [21:0] wd_last;
   logic        wd_armed_reg;
   logic        wd_clear;
   logic        wd_step;
   logic        wd_fire;
   logic [23:0] cm_cnt_reg;
   logic        cm_fire;
   logic        bus_wr;
   logic [7:0]  wbyte;
   logic [7:0]  rd_val;

   function automatic logic [15:0] vec_of(input rwcm_cause_e c, input logic sp);
      logic [15:0] v;
      v = sp ? VEC_PIN_S : VEC_PIN_N;
      if (c == CAUSE_CM) begin
         v = sp ? VEC_CM_S : VEC_CM_N;
      end else if (c == CAUSE_WD) begin
         v = sp ? VEC_WD_S : VEC_WD_N;
      end
      return v;
   endfunction

   // ------------------------------------------------------------
   // Pin synchronisers: reset pin, mode strap, monitored clock
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_reg    <= 3'h7;
         sync_reg    <= 3'h7;
         mc_prev_reg <= 1'h0;
      end else if (clk_en) begin
         meta_reg    <= {mon_clk, special_mode, rst_pin_i};
         sync_reg    <= meta_reg;
         mc_prev_reg <= sync_reg[2];
      end
   end

   assign pin_s  = sync_reg[0];
   assign mode_s = sync_reg[1];
   assign in_rst = (state_reg != ST_RUN);

   // ------------------------------------------------------------
   // E clock tick
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ediv_reg <= 2'h0;
      end else if (clk_en) begin
         ediv_reg <= ediv_reg + 2'h1;
      end
   end

   assign e_tick = (ediv_reg == E_DIV_LAST);

   // ------------------------------------------------------------
   // Reset sequencer
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg    <= ST_POR;
         seq_cnt_reg  <= 12'h000;
         pend_reg     <= CAUSE_POR;
         cpu_reset    <= 1'h1;
         rst_pin_o    <= 1'h0;
         rst_pin_oe   <= 1'h0;
         reset_cause  <= CAUSE_POR;
         reset_vector <= VEC_PIN_N;
      end else if (clk_en) begin
         case (state_reg)
            ST_POR: begin
               if (e_tick) begin
                  seq_cnt_reg <= seq_cnt_reg + 12'h001;
                  if (seq_cnt_reg == SEQ_POR_LAST) begin // see RL2
                     seq_cnt_reg  <= 12'h000;
                     state_reg    <= ST_HOLD;
                     reset_cause  <= CAUSE_POR;
                     reset_vector <= vec_of(CAUSE_POR, special_reg); // see RL19
                  end
               end
            end
            ST_DRIVE: begin
               rst_pin_oe <= 1'h1; // see RL4
               if (e_tick) begin
                  seq_cnt_reg <= seq_cnt_reg + 12'h001;
                  if (seq_cnt_reg == SEQ_DRV_LAST) begin
                     seq_cnt_reg <= 12'h000;
                     rst_pin_oe  <= 1'h0;
                     state_reg   <= ST_SAMPLE;
                  end
               end
            end
            ST_SAMPLE: begin
               if (e_tick) begin
                  seq_cnt_reg <= seq_cnt_reg + 12'h001;
                  if (seq_cnt_reg == SEQ_SMP_LAST) begin // see RL4
                     seq_cnt_reg <= 12'h000;
                     if (!pin_s) begin // see RL5
                        state_reg    <= ST_HOLD;
                        reset_cause  <= CAUSE_PIN;
                        reset_vector <= vec_of(CAUSE_PIN, special_reg); // see RL1
                     end else begin
                        state_reg    <= ST_RUN;
                        cpu_reset    <= 1'h0;
                        reset_cause  <= pend_reg;
                        reset_vector <= vec_of(pend_reg, special_reg); // see RL19
                     end
                  end
               end
            end
            ST_HOLD: begin
               if (pin_s) begin // see RL3
                  state_reg <= ST_RUN;
                  cpu_reset <= 1'h0;
               end
            end
            ST_RUN: begin
               // Clock failure wins over watchdog: a dead clock makes the count stale
               if (cm_fire) begin
                  pend_reg   <= CAUSE_CM;
                  state_reg  <= ST_DRIVE;
                  cpu_reset  <= 1'h1; // see RL6
                  rst_pin_oe <= 1'h1;
               end else if (wd_fire) begin
                  pend_reg   <= CAUSE_WD;
                  state_reg  <= ST_DRIVE;
                  cpu_reset  <= 1'h1; // see RL6
                  rst_pin_oe <= 1'h1;
               end else if (!pin_s) begin
                  pend_reg   <= CAUSE_PIN;
                  state_reg  <= ST_DRIVE;
                  cpu_reset  <= 1'h1;
                  rst_pin_oe <= 1'h1;
               end
            end
            default: begin
               state_reg <= ST_POR;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Values caught while in reset
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         special_reg    <= 1'h0;
         wd_dis_eff_reg <= CFG_WDDIS_RST;
      end else if (clk_en) begin
         if (in_rst) begin
            special_reg    <= mode_s;
            wd_dis_eff_reg <= cfg_wddis_reg; // see RL8
         end
      end
   end

   // ------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------
   assign bus_wr = avs_write & ~avs_waitrequest & avs_byteenable[0];
   assign wbyte  = avs_writedata[7:0];

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_wddis_reg <= CFG_WDDIS_RST;
      end else if (clk_en) begin
         // Stored value survives internal resets like a nonvolatile cell
         if (bus_wr && avs_address == {CFG_IDX, 2'b00}) begin
            cfg_wddis_reg <= wbyte[CFG_WDDIS_BIT]; // see RL21
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         inhibit_reg <= 1'h0;
      end else if (clk_en) begin
         if (in_rst) begin
            inhibit_reg <= mode_s; // see RL9
         end else if (bus_wr && avs_address == {TEST_IDX, 2'b00}) begin
            inhibit_reg <= wbyte[TEST_INH_BIT]; // see RL9
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         opt_reg       <= '0;
         rate_done_reg <= 1'h0;
         win_cnt_reg   <= 7'h00;
      end else if (clk_en) begin
         if (in_rst) begin
            opt_reg       <= '0; // see RL20
            rate_done_reg <= 1'h0;
            win_cnt_reg   <= 7'h00;
         end else begin
            if (e_tick && win_cnt_reg != RATE_WIN_E) begin
               win_cnt_reg <= win_cnt_reg + 7'h01;
            end
            if (bus_wr && avs_address == {OPT_IDX, 2'b00}) begin
               opt_reg.clock_monitor_enable <= wbyte[OPT_CME_BIT]; // see RL20
               if (special_reg) begin
                  opt_reg.rate <= wbyte[1:0];
               end else if (!rate_done_reg && win_cnt_reg != RATE_WIN_E) begin
                  opt_reg.rate  <= wbyte[1:0]; // see RL11
                  rate_done_reg <= 1'h1;
               end
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Watchdog
   // ------------------------------------------------------------
   assign wd_last  = (22'(WD_BASE_CYC) << {opt_reg.rate, 1'b0}) - 22'h000001; // see RL10
   assign wd_step  = e_tick & ~stop_mode; // see RL15
   assign wd_clear = bus_wr && avs_address == {WD_SVC_IDX, 2'b00} &&
                     wbyte == WD_CLR_VAL && wd_armed_reg; // see RL12
   assign wd_fire  = wd_step && wd_cnt_reg == wd_last && !wd_dis_eff_reg &&
                     !(special_reg && inhibit_reg); // see RL7

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         wd_armed_reg <= 1'h0;
      end else if (clk_en) begin
         if (in_rst) begin
            wd_armed_reg <= 1'h0; // see RL22
         end else if (bus_wr && avs_address == {WD_SVC_IDX, 2'b00}) begin
            if (wbyte == WD_ARM_VAL) begin
               wd_armed_reg <= 1'h1; // see RL12
            end else if (wbyte == WD_CLR_VAL) begin
               wd_armed_reg <= 1'h0;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         wd_cnt_reg <= 22'h000000;
      end else if (clk_en) begin
         if (in_rst || wd_clear) begin
            wd_cnt_reg <= 22'h000000; // see RL22
         end else if (wd_step) begin
            // A disabled watchdog just wraps, so enabling later starts clean
            wd_cnt_reg <= (wd_cnt_reg >= wd_last) ? 22'h000000 : wd_cnt_reg + 22'h000001;
         end
      end
   end

   // ------------------------------------------------------------
   // Clock monitor, timed on sys_clk instead of the watched clock
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cm_cnt_reg <= 24'h000000;
      end else if (clk_en) begin
         if (in_rst || sync_reg[2] != mc_prev_reg) begin
            cm_cnt_reg <= 24'h000000; // see RL14
         end else if (cm_cnt_reg != 24'(CM_TIMEOUT_CYC)) begin
            cm_cnt_reg <= cm_cnt_reg + 24'h000001; // see RL16
         end
      end
   end

   // Stop mode halts the watched clock, so it counts as a failure at once
   assign cm_fire = opt_reg.clock_monitor_enable &&
                    (cm_cnt_reg == 24'(CM_TIMEOUT_CYC) || stop_mode); // see RL13 see RL17

   // ------------------------------------------------------------
   // Avalon-MM slave, one wait state per access
   // ------------------------------------------------------------
   always_comb begin
      rd_val = 8'h00;
      if (avs_address == {OPT_IDX, 2'b00}) begin
         rd_val[OPT_CME_BIT] = opt_reg.clock_monitor_enable;
         rd_val[1:0]         = opt_reg.rate;
      end else if (avs_address == {CFG_IDX, 2'b00}) begin
         rd_val[CFG_WDDIS_BIT] = cfg_wddis_reg;
      end else if (avs_address == {TEST_IDX, 2'b00}) begin
         rd_val[TEST_INH_BIT] = inhibit_reg;
      end else if (avs_address == {STAT_IDX, 2'b00}) begin
         rd_val[1:0]          = reset_cause;
         rd_val[STAT_RST_BIT] = cpu_reset;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         avs_waitrequest <= 1'h1;
         avs_readdata    <= 32'h00000000;
      end else if (clk_en) begin
         if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'h0;
            if (avs_read) begin
               avs_readdata <= {24'h000000, rd_val};
            end
         end else begin
            avs_waitrequest <= 1'h1;
         end
      end
   end

endmodule // rwcm_top

// >>> src/rwcm_pkg.sv
/*
 * Constants, types and register map of the reset, watchdog and clock
 * monitor block. Assumes a 200 MHz sys_clk and an E clock made from it.
 */
// How it works
// RL1 - Four reset causes; power-on and pin share a vector, others own
// RL2 - After power-up, hold reset 4064 clock cycles for the oscillator
// RL3 - Pin still low after the delay keeps reset until it rises
// RL4 - On any reset drive the pin low four E cycles, sample two later; power-on goes from ST_POR to ST_HOLD without driving the pin
// RL5 - Sampled low means external reset; high means watchdog or monitor; a pin reset released before the sample still reports CAUSE_PIN
// RL6 - Reset stops the CPU, clears control bits, supplies the cause vector
// RL7 - Enabled watchdog forces reset unless serviced before expiry
// RL8 - Watchdog enable comes from a stored bit, effective after next reset
// RL9 - Special modes start with watchdog resets inhibited until cleared
// RL10 - Timeout is E over 2^15, further divided by 1, 4, 16 or 64
// RL11 - Rate resets to zero; normal modes allow one write within 64 cycles
// RL12 - Service is 55 hex then AA hex, in order, before timeout
// RL13 - Enabled clock monitor resets when no clock edge within its delay
// RL14 - Monitor delay is timed independently of the watched clock
// RL15 - Watchdog stops when the clocks stop
// RL16 - Monitor flags below 10 kHz, never at 200 kHz or above
// RL17 - Monitor enabled while stop mode halts clocks gives a reset
// RL18 - Software should clear the monitor enable around stop mode
// RL19 - Vectors FFFE, FFFC, FFFA in normal modes, BFxx in special modes
// RL20 - Monitor enable is bit 3 of options, always writable, reset clears
// RL21 - Watchdog disable 0 lets timeout reset, 1 blocks it
// RL22 - Every reset clears the watchdog counter and its arming state
package rwcm_pkg;

   localparam int unsigned SYS_CLK_NS    = 5;
   localparam logic [1:0]  E_DIV_LAST    = 2'h3;
   localparam logic [11:0] SEQ_POR_LAST  = 12'hfdf;
   localparam logic [11:0] SEQ_DRV_LAST  = 12'h003;
   localparam logic [11:0] SEQ_SMP_LAST  = 12'h001;
   localparam logic [6:0]  RATE_WIN_E    = 7'h40;
   localparam int unsigned WD_BASE_E     = 32768;
   localparam int unsigned CM_RC_NS      = 50000;

   localparam logic [15:0] WD_SVC_IDX    = 16'h103a;
   localparam logic [15:0] OPT_IDX       = 16'h1039;
   localparam logic [15:0] CFG_IDX       = 16'h103f;
   localparam logic [15:0] TEST_IDX      = 16'h103e;
   localparam logic [15:0] STAT_IDX      = 16'h1030;

   localparam int unsigned OPT_CME_BIT   = 3;
   localparam int unsigned CFG_WDDIS_BIT = 2;
   localparam int unsigned TEST_INH_BIT  = 0;
   localparam int unsigned STAT_RST_BIT  = 2;

   localparam logic [7:0]  WD_ARM_VAL    = 8'h55;
   localparam logic [7:0]  WD_CLR_VAL    = 8'haa;
   localparam logic        CFG_WDDIS_RST = 1'h0;

   localparam logic [15:0] VEC_PIN_N     = 16'hfffe;
   localparam logic [15:0] VEC_CM_N      = 16'hfffc;
   localparam logic [15:0] VEC_WD_N      = 16'hfffa;
   localparam logic [15:0] VEC_PIN_S     = 16'hbffe;
   localparam logic [15:0] VEC_CM_S      = 16'hbffc;
   localparam logic [15:0] VEC_WD_S      = 16'hbffa;

   typedef enum logic [1:0] {
      CAUSE_POR = 2'b00,
      CAUSE_PIN = 2'b01,
      CAUSE_CM  = 2'b10,
      CAUSE_WD  = 2'b11
   } rwcm_cause_e;

   typedef enum logic [2:0] {
      ST_POR    = 3'b000,
      ST_DRIVE  = 3'b001,
      ST_SAMPLE = 3'b010,
      ST_HOLD   = 3'b011,
      ST_RUN    = 3'b100
   } rwcm_state_e;

   typedef struct packed {
      logic       clock_monitor_enable;
      logic [1:0] rate;
   } rwcm_opt_s;

endpackage

// >>> testbench/rwcm_top_sva.sv
/*
 * Checker for the reset sequencer: pin drive, sampling, vectors, bus answers.
 * Assumes the ports of rwcm_top and one clock domain on sys_clk.
 */
`timescale 1ns/10ps
module rwcm_top_chk
   import rwcm_pkg::*;
#(
   parameter int unsigned WD_BASE_CYC    = 16,
   parameter int unsigned CM_TIMEOUT_CYC = 20
) (
   input wire logic        sys_clk,
   input wire logic        rst_b,
   input wire logic        rst_pin_i,
   input wire logic        rst_pin_o,
   input wire logic        rst_pin_oe,
   input wire logic        cpu_reset,
   input wire logic [15:0] reset_vector,
   input wire logic [1:0]  reset_cause,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // ----------------------------------------
   // Reset pin sequence
   // ----------------------------------------
   // Drive is four E ticks; E is sys_clk/4, so allow a few clocks of phase
   sequence s_drive;
      rst_pin_oe[*8] ##[6:10] !rst_pin_oe;
   endsequence
   sequence s_sample_wait;
      cpu_reset[*5];
   endsequence
   a_drive_width: assert property ($rose(rst_pin_oe) |-> s_drive)
      else $error("pin drive width wrong");
   a_drive_cause: assert property ($rose(rst_pin_oe) |-> $rose(cpu_reset))
      else $error("pin driven without cpu reset");
   a_open_drain: assert property (rst_pin_oe |-> !rst_pin_o)
      else $error("pin data not low while driven");
   a_sample_gap: assert property ($fell(rst_pin_oe) |-> s_sample_wait)
      else $error("reset ended before pin sample");
   a_vector_cause: assert property ($fell(cpu_reset) |->
      reset_vector[7:0] == (reset_cause == 2'b10 ? 8'hfc : reset_cause == 2'b11 ? 8'hfa : 8'hfe)
      && (reset_vector[15:8] == 8'hff || reset_vector[15:8] == 8'hbf))
      else $error("vector does not match cause");
   a_pin_take: assert property ($fell(rst_pin_i) && !cpu_reset |-> ##[1:5] cpu_reset)
      else $error("low pin not taken as reset");
   a_pin_hold: assert property (cpu_reset && !rst_pin_i |=> cpu_reset)
      else $error("reset left while pin low");
   // ----------------------------------------
   // Register bus
   // ----------------------------------------
   a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest)
      else $error("bus answer late");
   a_bus_release: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("answer held too long");
   a_read_upper: assert property (!avs_waitrequest && $past(avs_read)
      |-> avs_readdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
endmodule // rwcm_top_chk

bind rwcm_top rwcm_top_chk #(.WD_BASE_CYC(WD_BASE_CYC), .CM_TIMEOUT_CYC(CM_TIMEOUT_CYC)) u_chk (
   .sys_clk(sys_clk), .rst_b(rst_b), .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o),
   .rst_pin_oe(rst_pin_oe), .cpu_reset(cpu_reset), .reset_vector(reset_vector),
   .reset_cause(reset_cause), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

// >>> testbench/rwcm_pin_model.sv
/*
 * External reset circuit on the open-drain reset pin, with its pull-up.
 * Assumes the bench commands how long the circuit holds the pin low.
 */
`timescale 1ns/10ps
module rwcm_pin_model (
   input  wire logic hold_low,
   input  wire logic rst_pin_oe,
   input  wire logic rst_pin_o,
   output logic      rst_pin
);
   // Wired level: any driver low wins, pull-up otherwise; never left floating
   assign rst_pin = !((rst_pin_oe && !rst_pin_o) || hold_low);
endmodule // rwcm_pin_model

// >>> testbench/rwcm_tb_top.sv
/*
 * Scenario bench for rwcm_top over Avalon-MM and the reset pin.
 * Assumes the pin model and shortened watchdog and monitor counts.
 */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
   $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module rwcm_tb_top
   import rwcm_pkg::*;
;
   logic        sys_clk, rst_b, hold_low, special_mode, mon_clk, mon_run, stop_mode;
   logic        rst_pin_i, rst_pin_o, rst_pin_oe, cpu_reset, avs_read, avs_write;
   logic        avs_waitrequest;
   logic [15:0] reset_vector;
   logic [1:0]  reset_cause;
   logic [17:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [7:0]  rd;
   int          failures, checked, cycles, n;
   // ----------------------------------------
   // Clock, monitored clock, timeout
   // ----------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (mon_run) mon_clk <= ~mon_clk;
      cycles <= cycles + 1;
      if (cycles == 50000) begin
         failures++;
         test_done();
      end
   end
   rwcm_top #(.WD_BASE_CYC(16), .CM_TIMEOUT_CYC(20)) DUT (
      .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1), .rst_pin_i(rst_pin_i),
      .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .special_mode(special_mode),
      .mon_clk(mon_clk), .stop_mode(stop_mode), .cpu_reset(cpu_reset),
      .reset_vector(reset_vector), .reset_cause(reset_cause), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   rwcm_pin_model PIN (.hold_low(hold_low), .rst_pin_oe(rst_pin_oe),
      .rst_pin_o(rst_pin_o), .rst_pin(rst_pin_i));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic idle(input int k);
      repeat (k) @(posedge sys_clk);
   endtask
   // One spare edge after release so the next request never re-drives in one step
   task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] d);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h0, d};
      avs_write <= wr;
      avs_read <= ~wr;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rdchk(input logic [15:0] idx, input logic [7:0] e, input string nm);
      bus(1'b0, idx, 8'h00);
      `CHK(nm, e, rd)
   endtask
   task automatic wcpu(input logic v, input int lim, output int k);
      k = 0;
      while (cpu_reset !== v && k < lim) begin
         @(posedge sys_clk);
         k++;
      end
   endtask
   task automatic ends(input logic [1:0] c, input logic [15:0] v);
      wcpu(1'b0, 200, n);
      `CHK("cause", c, reset_cause)
      `CHK("vector", v, reset_vector)
   endtask
   task automatic svc;
      bus(1'b1, WD_SVC_IDX, WD_ARM_VAL);
      bus(1'b1, WD_SVC_IDX, WD_CLR_VAL);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_power_up;
      idle(16400);
      `CHK("held", 1'b1, cpu_reset)
      `CHK("no_drive", 1'b0, rst_pin_oe)
      hold_low <= 1'b0;
      ends(CAUSE_POR, VEC_PIN_N);
   endtask
   task automatic t_registers;
      rdchk(STAT_IDX, 8'h00, "status");
      rdchk(16'h1031, 8'h00, "unmapped");
      rdchk(WD_SVC_IDX, 8'h00, "service");
      bus(1'b1, OPT_IDX, 8'h09);
      bus(1'b1, OPT_IDX, 8'h02);
      rdchk(OPT_IDX, 8'h01, "options");
   endtask
   task automatic t_watchdog;
      repeat (6) begin
         idle(150);
         svc();
      end
      `CHK("serviced", CAUSE_POR, reset_cause)
      svc();
      bus(1'b1, WD_SVC_IDX, WD_CLR_VAL);
      bus(1'b1, WD_SVC_IDX, WD_ARM_VAL);
      wcpu(1'b1, 400, n);
      `CHK("wd_rate1", 1'b1, n + 6 >= 248 && n + 6 <= 264)
      `CHK("drive", 1'b1, rst_pin_oe)
      ends(CAUSE_WD, VEC_WD_N);
      wcpu(1'b1, 400, n);
      `CHK("wd_rate0", 1'b1, n >= 58 && n <= 70)
      ends(CAUSE_WD, VEC_WD_N);
      rdchk(OPT_IDX, 8'h00, "opt_clr");
   endtask
   task automatic t_monitor;
      bus(1'b1, OPT_IDX, 8'h0b);
      idle(200);
      `CHK("mon_ok", CAUSE_WD, reset_cause)
      mon_run <= 1'b0;
      wcpu(1'b1, 400, n);
      `CHK("mon_time", 1'b1, n <= 30)
      ends(CAUSE_CM, VEC_CM_N);
      mon_run <= 1'b1;
      rdchk(OPT_IDX, 8'h00, "cme_clr");
      bus(1'b1, OPT_IDX, 8'h0b);
      stop_mode <= 1'b1;
      wcpu(1'b1, 400, n);
      `CHK("stop_time", 1'b1, n <= 30)
      ends(CAUSE_CM, VEC_CM_N);
      // Software keeps the monitor off while stopped, then turns it back on
      bus(1'b1, OPT_IDX, 8'h00);
      wcpu(1'b1, 200, n);
      `CHK("wd_frozen", 200, n)
      stop_mode <= 1'b0;
      bus(1'b1, OPT_IDX, 8'h08);
      wcpu(1'b1, 400, n);
      `CHK("wd_resume", 1'b1, n <= 70)
      ends(CAUSE_WD, VEC_WD_N);
   endtask
   task automatic t_special;
      special_mode <= 1'b1;
      rst_b <= 1'b0;
      idle(6);
      rst_b <= 1'b1;
      wcpu(1'b0, 20000, n);
      `CHK("por_len", 1'b1, n >= 16256 && n <= 16268)
      `CHK("vec_s", VEC_PIN_S, reset_vector)
      wcpu(1'b1, 300, n);
      `CHK("inhibit", 300, n)
      bus(1'b1, TEST_IDX, 8'h00);
      wcpu(1'b1, 400, n);
      `CHK("inh_off", 1'b1, n <= 70)
      ends(CAUSE_WD, VEC_WD_S);
      special_mode <= 1'b0;
   endtask
   task automatic t_pin;
      hold_low <= 1'b1;
      wcpu(1'b1, 400, n);
      `CHK("pin_take", 1'b1, n <= 6)
      idle(60);
      `CHK("pin_hold", 1'b1, cpu_reset)
      hold_low <= 1'b0;
      ends(CAUSE_PIN, VEC_PIN_N);
   endtask
   task automatic t_disable;
      bus(1'b1, CFG_IDX, 8'h04);
      rdchk(CFG_IDX, 8'h04, "config");
      wcpu(1'b1, 400, n);
      `CHK("not_yet", 1'b1, n <= 70)
      ends(CAUSE_WD, VEC_WD_N);
      wcpu(1'b1, 400, n);
      `CHK("disabled", 400, n)
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      rst_b = 1'b0;
      hold_low = 1'b1;
      special_mode = 1'b0;
      mon_clk = 1'b0;
      mon_run = 1'b1;
      stop_mode = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 18'h0;
      avs_writedata = 32'h0;
      failures = 0;
      checked = 0;
      cycles = 0;
      idle(6);
      rst_b <= 1'b1;
      t_power_up();
      t_registers();
      t_watchdog();
      t_monitor();
      t_special();
      t_pin();
      t_disable();
      test_done();
   end
endmodule // rwcm_tb_top
